// *** hdl/pflt_pkg.sv ***
package pflt_pkg;
  // Register map of the plain register port (index = address)
  localparam logic [3:0] MAIN_FREQ_ADDR = 4'h0;
  localparam logic [3:0] REF_DIV_ADDR = 4'h2;
  localparam logic [3:0] FUNC_CTRL_ADDR = 4'h4;
  localparam logic [3:0] RAMP_CTRL_ADDR = 4'h3;
  localparam logic [3:0] FRAC_ADDR = 4'h8;
  localparam logic [3:0] PUMP_ADDR = 4'h9;
  localparam logic [3:0] STATUS_ADDR = 4'ha;
  // Field positions
  localparam int INT_LSB = 15;
  localparam int INT_W = 12;
  localparam int FRAC_W = 25;
  localparam int WORD1_LSB = 3;
  localparam int WORD2_LSB = 7;
  localparam int WORD_W = 12;
  localparam int FLSEL_LSB = 19;
  localparam int RAMP_EN_BIT = 0;
  localparam int PUMP_W = 4;
  // Fast-lock select codes
  localparam logic [1:0] FLSEL_OFF = 2'h0;
  localparam logic [1:0] FLSEL_DIV = 2'h1;
  // Boost factor as a shift: 16 = 1 << 4
  localparam int BOOST_SHIFT = 4;
  // Reset values
  localparam logic [31:0] REG_RST = 32'h0000_0000;
endpackage : pflt_pkg

// *** hdl/pflt_interval_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
module pflt_interval_timer #(
  parameter int WORD_W = 12
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic pfdTick,
  input wire logic start,
  input wire logic [WORD_W-1:0] word1,
  input wire logic [WORD_W-1:0] word2,
  output logic active
);
  logic [2*WORD_W-1:0] count_r;
  logic [2*WORD_W-1:0] product;

  // Full-width product, so a result with zero low bits still counts as non-zero
  assign product = {{WORD_W{1'b0}}, word1} * {{WORD_W{1'b0}}, word2}; // R2

  // Load product on start, count down in reference periods
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_r <= '0;
      active <= 1'b0;
    end else if (ce) begin
      if (start) begin
        count_r <= product; // R2
        active <= (product != '0);
      end else if (active && pfdTick) begin
        count_r <= count_r - {{(2*WORD_W-1){1'b0}}, 1'b1};
        if (count_r == {{(2*WORD_W-1){1'b0}}, 1'b1}) begin
          active <= 1'b0; // R10
        end
      end
    end
  end
endmodule : pflt_interval_timer
`default_nettype wire

// *** hdl/pflt_sigma_delta.sv ***
`timescale 1ns/1ps
`default_nettype none
module pflt_sigma_delta #(
  parameter int FRAC_W = 25
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic pfdTick,
  input wire logic [FRAC_W-1:0] frac,
  output logic signed [3:0] nOffset
);
  logic [FRAC_W-1:0] acc1_r;
  logic [FRAC_W-1:0] acc2_r;
  logic [FRAC_W-1:0] acc3_r;
  logic c1;
  logic c2;
  logic c3;
  logic [FRAC_W-1:0] s1;
  logic [FRAC_W-1:0] s2;
  logic [FRAC_W-1:0] s3;
  logic c2_d1_r;
  logic c3_d1_r;
  logic c3_d2_r;

  // MASH 1-1-1 accumulators, modulus 2^FRAC_W by natural wrap
  assign {c1, s1} = {1'b0, acc1_r} + {1'b0, frac};
  assign {c2, s2} = {1'b0, acc2_r} + {1'b0, s1};
  assign {c3, s3} = {1'b0, acc3_r} + {1'b0, s2};

  // Update once per reference cycle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      acc1_r <= '0;
      acc2_r <= '0;
      acc3_r <= '0;
      c2_d1_r <= 1'b0;
      c3_d1_r <= 1'b0;
      c3_d2_r <= 1'b0;
      nOffset <= 4'sh0;
    end else if (ce && pfdTick) begin
      acc1_r <= s1; // R9
      acc2_r <= s2;
      acc3_r <= s3;
      c2_d1_r <= c2;
      c3_d1_r <= c3;
      c3_d2_r <= c3_d1_r;
      nOffset <= $signed({3'h0, c1}) + $signed({3'h0, c2}) - $signed({3'h0, c2_d1_r})
        + $signed({3'h0, c3}) - $signed({2'h0, c3_d1_r, 1'b0}) + $signed({3'h0, c3_d2_r});
    end
  end
endmodule : pflt_sigma_delta
`default_nettype wire

// *** hdl/pflt_fast_lock.sv ***
// Design decisions made here: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// (R1) Main register write starts wide-bandwidth interval
// (R2) Interval equals word1 times word2 periods
// (R3) Word1 from reference divider bits 14:3
// (R4) Word2 from function control bits 18:7
// (R5) No fast lock while ramp active; only a start is blocked, a running interval continues
// (R6) Host initializes before enabling fast lock
// (R7) Pump current sixteen times during interval
// (R8) Divider code: ground and pump switches close
// (R9) Third-order interpolator, modulus two^25, per cycle
// (R10) Expiry restores current, opens switches
module pflt_fast_lock #(
  parameter int WORD_W = 12,
  parameter int FRAC_W = 25
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic pfdTick,
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  output logic fastLockActive,
  output logic groundSwitchOutput,
  output logic pumpSwitchOutput,
  output logic [pflt_pkg::PUMP_W+pflt_pkg::BOOST_SHIFT-1:0] chargePumpLevel,
  output logic [11:0] intWord,
  output logic signed [3:0] nOffset
);
  logic [31:0] mainFreq_r;
  logic [31:0] refDiv_r;
  logic [31:0] funcCtrl_r;
  logic [31:0] rampCtrl_r;
  logic [FRAC_W-1:0] frac_r;
  logic [pflt_pkg::PUMP_W-1:0] pump_r;
  logic [1:0] flSel;
  logic rampOn;
  logic startFl;
  logic timerActive;
  logic [31:0] rdNxt;
  logic [WORD_W-1:0] word1;
  logic [WORD_W-1:0] word2;

  assign flSel = funcCtrl_r[pflt_pkg::FLSEL_LSB +: 2];
  assign rampOn = rampCtrl_r[pflt_pkg::RAMP_EN_BIT];
  assign word1 = refDiv_r[pflt_pkg::WORD1_LSB +: WORD_W]; // R3
  assign word2 = funcCtrl_r[pflt_pkg::WORD2_LSB +: WORD_W]; // R4

  // Start pulse: main register write with fast lock selected and no ramp
  assign startFl = regWr && (regAddr == pflt_pkg::MAIN_FREQ_ADDR)
    && (flSel != pflt_pkg::FLSEL_OFF) && !rampOn; // R1 R5

  // Register writes
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mainFreq_r <= pflt_pkg::REG_RST;
      refDiv_r <= pflt_pkg::REG_RST;
      funcCtrl_r <= pflt_pkg::REG_RST;
      rampCtrl_r <= pflt_pkg::REG_RST;
      frac_r <= '0;
      pump_r <= '0;
    end else if (ce && regWr) begin
      case (regAddr)
        pflt_pkg::MAIN_FREQ_ADDR: mainFreq_r <= regWdata;
        pflt_pkg::REF_DIV_ADDR: refDiv_r <= regWdata;
        pflt_pkg::FUNC_CTRL_ADDR: funcCtrl_r <= regWdata;
        pflt_pkg::RAMP_CTRL_ADDR: rampCtrl_r <= regWdata;
        pflt_pkg::FRAC_ADDR: frac_r <= regWdata[FRAC_W-1:0];
        pflt_pkg::PUMP_ADDR: pump_r <= regWdata[pflt_pkg::PUMP_W-1:0];
        default: ;
      endcase
    end
  end

  // Read mux, data valid the cycle after the strobe
  always_comb begin
    case (regAddr)
      pflt_pkg::MAIN_FREQ_ADDR: rdNxt = mainFreq_r;
      pflt_pkg::REF_DIV_ADDR: rdNxt = refDiv_r;
      pflt_pkg::FUNC_CTRL_ADDR: rdNxt = funcCtrl_r;
      pflt_pkg::RAMP_CTRL_ADDR: rdNxt = rampCtrl_r;
      pflt_pkg::FRAC_ADDR: rdNxt = {{(32-FRAC_W){1'b0}}, frac_r};
      pflt_pkg::PUMP_ADDR: rdNxt = {{(32-pflt_pkg::PUMP_W){1'b0}}, pump_r};
      pflt_pkg::STATUS_ADDR: rdNxt = {31'h0, timerActive};
      default: rdNxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      regRdata <= 32'h0000_0000;
    end else if (ce) begin
      regRdata <= regRd ? rdNxt : 32'h0000_0000;
    end
  end

  // Interval timer
  pflt_interval_timer #(.WORD_W(WORD_W)) u_timer (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .pfdTick(pfdTick),
    .start(startFl),
    .word1(word1),
    .word2(word2),
    .active(timerActive)
  );

  // Fractional interpolator
  pflt_sigma_delta #(.FRAC_W(FRAC_W)) u_sdm (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .pfdTick(pfdTick),
    .frac(frac_r),
    .nOffset(nOffset)
  );

  // Registered outputs; all but intWord (taken from the main register) driven by the interval state
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fastLockActive <= 1'b0;
      groundSwitchOutput <= 1'b0;
      pumpSwitchOutput <= 1'b0;
      chargePumpLevel <= '0;
      intWord <= 12'h000;
    end else if (ce) begin
      fastLockActive <= timerActive;
      intWord <= mainFreq_r[pflt_pkg::INT_LSB +: pflt_pkg::INT_W];
      groundSwitchOutput <= timerActive && (flSel == pflt_pkg::FLSEL_DIV); // R8 R10
      pumpSwitchOutput <= timerActive && (flSel == pflt_pkg::FLSEL_DIV); // R8 R10
      if (timerActive) begin
        chargePumpLevel <= {pump_r, {pflt_pkg::BOOST_SHIFT{1'b0}}}; // R7
      end else begin
        chargePumpLevel <= {{pflt_pkg::BOOST_SHIFT{1'b0}}, pump_r}; // R10
      end
    end
  end
endmodule : pflt_fast_lock
`default_nettype wire

// *** dv/pflt_fast_lock_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module pflt_fast_lock_sva (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic pfdTick,
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [31:0] regRdata,
  input wire logic fastLockActive,
  input wire logic groundSwitchOutput,
  input wire logic pumpSwitchOutput,
  input wire logic [7:0] chargePumpLevel
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic rampOn_r;
  wire logic mainWr = regWr && regAddr == pflt_pkg::MAIN_FREQ_ADDR;
  // Mirror of the ramp enable bit
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) rampOn_r <= 1'b0;
    else if (ce && regWr && regAddr == pflt_pkg::RAMP_CTRL_ADDR) rampOn_r <= regWdata[pflt_pkg::RAMP_EN_BIT];
  end
  property p_start; $rose(fastLockActive) |-> $past(mainWr, 2); endproperty
  a_start: assert property (p_start) else $error("rise without main write");
  property p_ramp; $rose(fastLockActive) |-> !$past(rampOn_r, 2); endproperty
  a_ramp: assert property (p_ramp) else $error("rise under ramp");
  // A main write with a zero product also ends the interval, without a tick
  property p_end; $fell(fastLockActive) |-> $past(pfdTick, 2) || $past(mainWr, 2); endproperty
  a_end: assert property (p_end) else $error("end off tick");
  property p_sw; groundSwitchOutput |-> fastLockActive && pumpSwitchOutput; endproperty
  a_sw: assert property (p_sw) else $error("switch outside interval");
  property p_pair; pumpSwitchOutput |-> groundSwitchOutput; endproperty
  a_pair: assert property (p_pair) else $error("switches split");
  property p_boost; fastLockActive |-> chargePumpLevel[3:0] == 4'h0; endproperty
  a_boost: assert property (p_boost) else $error("no boost");
  property p_norm; !fastLockActive |-> chargePumpLevel[7:4] == 4'h0; endproperty
  a_norm: assert property (p_norm) else $error("boost stuck");
  property p_rd; !$past(regRd) |-> regRdata == 32'h0; endproperty
  a_rd: assert property (p_rd) else $error("read data outside slot");
  c_rise: cover property ($rose(fastLockActive));
  c_fall: cover property ($fell(fastLockActive));
  c_sw: cover property ($rose(groundSwitchOutput));
endmodule : pflt_fast_lock_sva
bind pflt_fast_lock pflt_fast_lock_sva pflt_fast_lock_sva_inst (
  .clk(clk),
  .sys_rst(sys_rst),
  .ce(ce),
  .pfdTick(pfdTick),
  .regAddr(regAddr),
  .regWdata(regWdata),
  .regWr(regWr),
  .regRd(regRd),
  .regRdata(regRdata),
  .fastLockActive(fastLockActive),
  .groundSwitchOutput(groundSwitchOutput),
  .pumpSwitchOutput(pumpSwitchOutput),
  .chargePumpLevel(chargePumpLevel)
);
`default_nettype wire

// *** dv/pflt_ref_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module pflt_ref_model #(
  parameter int DIV = 4
) (
  input wire logic clk,
  input wire logic sys_rst,
  output logic pfdTick
);
  int tickCnt_r;
  // Reference pulse one clock long every DIV clocks
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) tickCnt_r <= 0;
    else tickCnt_r <= (tickCnt_r == DIV - 1) ? 0 : tickCnt_r + 1;
  end
  assign pfdTick = (tickCnt_r == DIV - 1);
endmodule : pflt_ref_model
`default_nettype wire

// *** dv/tb_pflt_fast_lock.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_pflt_fast_lock;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic ce = 1'b1;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [31:0] regWdata = 32'h0;
  logic [31:0] regRdata;
  logic pfdTick, fastLockActive, groundSwitchOutput, pumpSwitchOutput;
  logic [7:0] chargePumpLevel;
  logic [11:0] intWord;
  logic signed [3:0] nOffset;
  int seed = 32'hc5ca9174;
  int fails = 0;
  int totalChecks = 0;
  always #2 clk = ~clk;
  pflt_ref_model #(.DIV(4)) pflt_ref_model_inst (.clk(clk), .sys_rst(sys_rst), .pfdTick(pfdTick));
  pflt_fast_lock pflt_fast_lock_inst (
    .clk(clk), .sys_rst(sys_rst), .ce(ce), .pfdTick(pfdTick),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .fastLockActive(fastLockActive), .groundSwitchOutput(groundSwitchOutput),
    .pumpSwitchOutput(pumpSwitchOutput), .chargePumpLevel(chargePumpLevel),
    .intWord(intWord), .nOffset(nOffset)
  );
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    @(negedge clk);
    check(regRdata, exp);
  endtask : rd
  task automatic tally_and_finish;
    if (fails == 0 && totalChecks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : tally_and_finish
  // Random intervals over every select code, with restart and ramp cases
  initial begin
    int w1, w2, sel, n, j, k;
    logic [7:0] pump;
    logic exp;
    logic [31:0] mainV;
    logic [31:0] fracV;
    longint sum;
    longint lim;
    logic tickSeen;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    rd(pflt_pkg::STATUS_ADDR, 32'h0);
    rd(4'hf, 32'h0);
    for (int a = 0; a < 10; a++) wr(a[3:0], 32'h0);
    for (int i = 0; i < 8; i++) begin
      w1 = 1 + {$random(seed)} % 6;
      w2 = 1 + {$random(seed)} % 6;
      if (i == 5) w1 = 1;
      if (i == 5) w2 = 1;
      if (i == 1) w1 = 64; // Product 4096: low twelve bits zero
      if (i == 1) w2 = 64;
      if (i == 3) w2 = 0; // Zero product starts nothing
      sel = i % 4;
      pump = 1 + {$random(seed)} % 15;
      exp = sel != 0 && i != 7 && w2 != 0;
      wr(pflt_pkg::REF_DIV_ADDR, (w1 << 3) | 7);
      wr(pflt_pkg::FUNC_CTRL_ADDR, (sel << 19) | (w2 << 7) | 32'h7f);
      wr(pflt_pkg::PUMP_ADDR, pump);
      wr(pflt_pkg::RAMP_CTRL_ADDR, i == 7);
      wr(pflt_pkg::FRAC_ADDR, $random(seed));
      mainV = $random(seed);
      wr(pflt_pkg::MAIN_FREQ_ADDR, mainV);
      if (i == 6) begin
        mainV = $random(seed);
        wr(pflt_pkg::MAIN_FREQ_ADDR, mainV);
      end
      n = 0;
      j = 0;
      while (j < w1 * w2 * 4 + 8) begin
        @(negedge clk);
        if (j > 0 && !fastLockActive) break;
        if (j > 0) check(chargePumpLevel, pump << 4);
        if (j > 0) check({groundSwitchOutput, pumpSwitchOutput}, {2{sel == 1}});
        n += pfdTick;
        j++;
      end
      check(j > 1, exp);
      if (exp) check(n, w1 * w2);
      check({groundSwitchOutput, pumpSwitchOutput, chargePumpLevel}, pump);
      check(intWord, mainV[pflt_pkg::INT_LSB +: pflt_pkg::INT_W]);
      rd(pflt_pkg::STATUS_ADDR, 32'h0);
      rd(pflt_pkg::REF_DIV_ADDR, (w1 << 3) | 7);
    end
    // Interpolator output summed over reference cycles tracks frac / 2^25 within the error band
    for (int f = 0; f < 2; f++) begin
      fracV = (f == 0) ? 32'h01ff_ffff : ($random(seed) & 32'h01ff_ffff);
      wr(pflt_pkg::FRAC_ADDR, fracV);
      sum = 0;
      k = 0;
      tickSeen = 1'b0;
      repeat (256) begin
        @(negedge clk);
        if (tickSeen) sum += nOffset;
        if (tickSeen) k++;
        tickSeen = pfdTick;
      end
      lim = (longint'(k) * longint'(fracV)) >>> pflt_pkg::FRAC_W;
      check(sum >= lim - 3 && sum <= lim + 4, 1'b1);
    end
    // Clock enable low freezes the register file, so this write is lost
    @(posedge clk);
    ce <= 1'b0;
    wr(pflt_pkg::PUMP_ADDR, pump ^ 8'h0f);
    ce <= 1'b1;
    rd(pflt_pkg::PUMP_ADDR, pump);
    tally_and_finish;
  end
  // Watchdog against a hung run, well beyond the longest interval
  initial begin
    #200000;
    fails++;
    tally_and_finish;
  end
endmodule : tb_pflt_fast_lock
`default_nettype wire
